// ==== sppm_pkg.sv ====
// Package: constants and carrier types for the SPI peripheral-mode port
package sppm_pkg;
  localparam int unsigned CtrlSelectBit = 0;
  localparam int unsigned FmtPhaseBit = 16;
  localparam int unsigned FmtPolarityBit = 17;
  localparam int unsigned FmtPrescaleLsb = 8;
  localparam int unsigned FmtPrescaleMsb = 15;
  localparam int unsigned FmtWidth = 18;
  localparam int unsigned WordBits = 16;
  localparam int unsigned CountWidth = 5;
  localparam logic [15:0] TxResetWord = 16'h0000;
  localparam int unsigned LinkPeriodMinNs = 25;
  localparam int unsigned CoreClkPeriodNs = 8;
  localparam int unsigned LinkPeriodMinCycles = (LinkPeriodMinNs + CoreClkPeriodNs - 1) / CoreClkPeriodNs;

  typedef struct packed {
    logic serialClock;
    logic selectN;
    logic hostOutData;
  } sppm_link_in_s;

  typedef struct packed {
    logic deviceOutData;
    logic deviceOutEn;
  } sppm_link_out_s;
endpackage

// ==== sppm_port.sv ====
// SPI peripheral-mode port: host-clocked 16-bit shift engine
`timescale 1ns/1ps
`default_nettype none
module sppm_port #(
  parameter int unsigned WORD_BITS = sppm_pkg::WordBits
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration
  input wire logic [31:0] globalControl,
  input wire logic [sppm_pkg::FmtWidth-1:0] formatControl,
  // Link pins
  input wire sppm_pkg::sppm_link_in_s linkIn,
  output sppm_pkg::sppm_link_out_s linkOut,
  // User side
  input wire logic [WORD_BITS-1:0] txWord,
  output logic [WORD_BITS-1:0] rxWord,
  output logic rxValid,
  output logic txTaken,
  output logic clockTooFast,
  output logic [sppm_pkg::CountWidth-1:0] bitCount
);
  logic peripheralMode;
  logic clockPhase;
  logic clockPolarity;
  logic [7:0] prescale;
  logic [8:0] minPeriod;
  logic sclkPrev;
  logic next_sclkPrev;
  logic risingEdge;
  logic fallingEdge;
  logic leadEdge;
  logic trailEdge;
  logic captureEdge;
  logic launchEdge;
  logic selected;
  logic [WORD_BITS-1:0] shiftOut;
  logic [WORD_BITS-1:0] next_shiftOut;
  logic [WORD_BITS-1:0] shiftIn;
  logic [WORD_BITS-1:0] next_shiftIn;
  logic [WORD_BITS-1:0] next_rxWord;
  logic next_rxValid;
  logic next_txTaken;
  logic [sppm_pkg::CountWidth-1:0] next_bitCount;
  logic outBit;
  logic next_outBit;
  logic outEn;
  logic next_outEn;
  logic loaded;
  logic next_loaded;
  logic [8:0] periodCount;
  logic [8:0] next_periodCount;
  logic next_clockTooFast;

  assign peripheralMode = ~globalControl[sppm_pkg::CtrlSelectBit];
  assign clockPhase = formatControl[sppm_pkg::FmtPhaseBit];
  assign clockPolarity = formatControl[sppm_pkg::FmtPolarityBit];
  assign prescale = formatControl[sppm_pkg::FmtPrescaleMsb:sppm_pkg::FmtPrescaleLsb];
  // Shortest period the prescale allows, in core cycles; prescale 0 still needs two
  assign minPeriod = (prescale == 8'h00) ? 9'h002 : ({1'b0, prescale} + 9'h001);
  assign selected = peripheralMode & ~linkIn.selectN;
  assign risingEdge = linkIn.serialClock & ~sclkPrev;
  assign fallingEdge = ~linkIn.serialClock & sclkPrev;
  // Leading edge leaves idle level; polarity picks which edge that is
  assign leadEdge = clockPolarity ? fallingEdge : risingEdge;
  assign trailEdge = clockPolarity ? risingEdge : fallingEdge;
  // Phase 1 launches on the leading edge, rising at polarity 0 and falling at polarity 1;
  // phase 0 puts bit 15 on the line before any edge and launches the rest on the trailing edge
  assign launchEdge = clockPhase ? leadEdge : trailEdge;
  assign captureEdge = clockPhase ? trailEdge : leadEdge;

  always_comb begin
    next_sclkPrev = linkIn.serialClock;
    next_shiftOut = shiftOut;
    next_shiftIn = shiftIn;
    next_rxWord = rxWord;
    next_rxValid = 1'b0;
    next_txTaken = 1'b0;
    next_bitCount = bitCount;
    next_outBit = outBit;
    next_outEn = selected;
    next_loaded = loaded;
    next_periodCount = periodCount;
    next_clockTooFast = clockTooFast;
    if (!selected) begin
      next_bitCount = '0;
      next_outBit = 1'b0;
      next_loaded = 1'b0;
      next_periodCount = '0;
    end else begin
      if (!loaded) begin
        // Phase 0 needs the first bit on the line before any edge
        next_shiftOut = txWord;
        next_outBit = txWord[WORD_BITS-1];
        next_loaded = 1'b1;
        next_txTaken = 1'b1;
      end
      if (periodCount != 9'h1ff) begin
        next_periodCount = periodCount + 9'h001;
      end
      if (leadEdge) begin
        next_periodCount = 9'h001;
        // A host that clocks faster than the prescale allows is flagged, sticky until reset
        if (bitCount != '0 && (periodCount < minPeriod ||
            periodCount < 9'(sppm_pkg::LinkPeriodMinCycles))) begin
          next_clockTooFast = 1'b1;
        end
      end
      if (captureEdge && loaded) begin
        next_shiftIn = {shiftIn[WORD_BITS-2:0], linkIn.hostOutData};
        if (bitCount == sppm_pkg::CountWidth'(WORD_BITS - 1)) begin
          next_rxWord = {shiftIn[WORD_BITS-2:0], linkIn.hostOutData};
          next_rxValid = 1'b1;
          next_bitCount = '0;
        end else begin
          next_bitCount = bitCount + 1'b1;
        end
      end
      if (launchEdge && loaded) begin
        // Phase 1 launches on the lead edge, so bit 15 goes out on the first one
        if (clockPhase && bitCount == '0 && !captureEdge) begin
          next_outBit = shiftOut[WORD_BITS-1];
        end else begin
          next_shiftOut = {shiftOut[WORD_BITS-2:0], 1'b0};
          next_outBit = shiftOut[WORD_BITS-2];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclkPrev <= 1'b0;
      shiftOut <= sppm_pkg::TxResetWord;
      shiftIn <= '0;
      rxWord <= '0;
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      bitCount <= '0;
      outBit <= 1'b0;
      outEn <= 1'b0;
      loaded <= 1'b0;
      periodCount <= '0;
      clockTooFast <= 1'b0;
    end else begin
      sclkPrev <= next_sclkPrev;
      shiftOut <= next_shiftOut;
      shiftIn <= next_shiftIn;
      rxWord <= next_rxWord;
      rxValid <= next_rxValid;
      txTaken <= next_txTaken;
      bitCount <= next_bitCount;
      outBit <= next_outBit;
      outEn <= next_outEn;
      loaded <= next_loaded;
      periodCount <= next_periodCount;
      clockTooFast <= next_clockTooFast;
    end
  end

  // Output enable lags select by one cycle; the host must not sample before its first edge
  // The bit register is cleared on deselect, so the data pin needs no gate after the flop
  assign linkOut = '{deviceOutData: outBit, deviceOutEn: outEn};

  AST_DRIVE_ONLY_SELECTED: assert property (@(posedge core_clk) disable iff (rst)
    linkIn.selectN |=> !linkOut.deviceOutEn)
    else $error("data line driven while deselected");
  AST_COUNT_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    linkIn.selectN |=> bitCount == '0)
    else $error("bit counter not cleared on deselect");
  AST_CONTROLLER_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    globalControl[sppm_pkg::CtrlSelectBit] |=> !linkOut.deviceOutEn && !rxValid)
    else $error("port active in controller mode");
  AST_CAPTURE_COUNTS: assert property (@(posedge core_clk) disable iff (rst)
    selected && loaded && captureEdge && bitCount < 5'd15 |=> bitCount == $past(bitCount) + 5'd1)
    else $error("capture edge did not advance count");
  sequence wordEnd_seq;
    selected && loaded && captureEdge && bitCount == 5'd15;
  endsequence
  AST_WORD_DONE: assert property (@(posedge core_clk) disable iff (rst)
    wordEnd_seq |=> rxValid && bitCount == 5'd0)
    else $error("word not delivered after sixteenth bit");
  AST_LAUNCH_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    selected && loaded && clockPhase && bitCount != 5'd0
      && (clockPolarity ? fallingEdge : risingEdge) |=> outBit == $past(shiftOut[WORD_BITS-2]))
    else $error("output not updated on launch edge");
  AST_HOLD_NO_EDGE: assert property (@(posedge core_clk) disable iff (rst)
    selected && loaded && !risingEdge && !fallingEdge |=> $stable(outBit) && $stable(bitCount))
    else $error("state moved without a clock edge");
  AST_FAST_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    selected && leadEdge && bitCount != 5'd0 && periodCount < minPeriod |=> clockTooFast)
    else $error("short clock period not flagged");
  AST_PRESCALE_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    selected && leadEdge && bitCount != 5'd0 && prescale == 8'h00 && !clockTooFast
      && periodCount >= 9'(sppm_pkg::LinkPeriodMinCycles) |=> !clockTooFast)
    else $error("legal period flagged at prescale zero");
  AST_MIN_PERIOD_NS: assert property (@(posedge core_clk) disable iff (rst)
    selected && leadEdge && bitCount != 5'd0 && periodCount < 9'(sppm_pkg::LinkPeriodMinCycles) |=> clockTooFast)
    else $error("period under the absolute minimum not flagged");
  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (rst)
    clockTooFast |=> clockTooFast)
    else $error("fast-clock flag cleared without reset");
  sequence load_seq;
    selected && !loaded;
  endsequence
  AST_FIRST_BIT: assert property (@(posedge core_clk) disable iff (rst)
    load_seq |=> txTaken && linkOut.deviceOutEn && linkOut.deviceOutData == $past(txWord[WORD_BITS-1]))
    else $error("first bit not on the line after select");
  AST_RX_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    rxValid |=> !rxValid)
    else $error("word valid held longer than one cycle");
  AST_TX_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    txTaken |=> !txTaken)
    else $error("transmit load pulse held longer than one cycle");
endmodule
`default_nettype wire

// ==== sppm_host.sv ====
// Host-side model that clocks the peripheral port
`timescale 1ns/1ps
`default_nettype none
module sppm_host (
  // Clock
  input wire logic core_clk,
  // Link pins
  output var sppm_pkg::sppm_link_in_s linkIn,
  input wire sppm_pkg::sppm_link_out_s linkOut
);
  initial linkIn = 3'b010;
  task automatic xfer(input logic pol, input logic ph, input logic [15:0] w, input int n, input int h,
                      output logic [15:0] r);
    r = 16'h0000;
    @(posedge core_clk);
    linkIn.serialClock <= pol;
    @(posedge core_clk);
    linkIn.selectN <= 1'b0;
    // Two serial periods before the first edge
    repeat (4 * h) @(posedge core_clk);
    for (int i = 15; i > 15 - n; i--) begin
      if (!ph) linkIn.hostOutData <= w[i];
      // Half period h gives a full period of 2h cycles, at or above both bounds only while prescale is below 2h
      repeat (h) @(posedge core_clk);
      linkIn.serialClock <= ~linkIn.serialClock;
      if (ph) linkIn.hostOutData <= w[i];
      else r = {r[14:0], linkOut.deviceOutData};
      repeat (h) @(posedge core_clk);
      linkIn.serialClock <= ~linkIn.serialClock;
      if (ph) r = {r[14:0], linkOut.deviceOutData};
    end
    repeat (h) @(posedge core_clk);
    // Every word gets its own select pulse; released data shows the inverse
    linkIn.selectN <= 1'b1;
    linkIn.hostOutData <= ~linkIn.hostOutData;
    repeat (h) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== sppm_port_test.sv ====
// Self-checking bench for the peripheral-mode port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin errorCnt++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module sppm_port_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] globalControl = 32'h0;
  logic [sppm_pkg::FmtWidth-1:0] formatControl = '0;
  sppm_pkg::sppm_link_in_s linkIn;
  sppm_pkg::sppm_link_out_s linkOut;
  logic [15:0] txWord = 16'h0000;
  logic [15:0] rxWord;
  logic [15:0] expW;
  logic rxValid;
  logic txTaken;
  logic clockTooFast;
  logic [sppm_pkg::CountWidth-1:0] bitCount;
  logic [31:0] seed = 32'h0a5c;
  logic [15:0] expRx[$];
  int errorCnt = 0;
  int nCompared = 0;
  int nTaken = 0;
  int expTaken = 0;
  always #4 core_clk = ~core_clk;
  sppm_port u_sppm_port (.core_clk(core_clk), .rst(rst), .globalControl(globalControl),
    .formatControl(formatControl), .linkIn(linkIn), .linkOut(linkOut), .txWord(txWord),
    .rxWord(rxWord), .rxValid(rxValid), .txTaken(txTaken), .clockTooFast(clockTooFast),
    .bitCount(bitCount));
  sppm_host u_sppm_host (.core_clk(core_clk), .linkIn(linkIn), .linkOut(linkOut));
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    if (errorCnt == 0 && nCompared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Words may only complete when the driver noted one
  always @(posedge core_clk) begin
    if (txTaken === 1'b1) begin
      nTaken++;
    end
    if (rxValid === 1'b1) begin
      if (expRx.size() == 0) `CHK("rxUnexpected", 1'b0, 1'b1)
      else begin
        expW = expRx.pop_front();
        `CHK("rxWord", expW, rxWord)
      end
    end
  end
  // Only whole words in peripheral mode are expected back; partial words still show their leading bits
  task automatic frame(input logic [1:0] mode, input logic [7:0] ps, input int n);
    logic [15:0] r;
    logic [31:0] s;
    logic full;
    logic idle;
    logic [15:0] expOut;
    seed = lfsrNext(seed);
    s = seed;
    @(posedge core_clk);
    idle = globalControl[sppm_pkg::CtrlSelectBit];
    full = (n == 16) && !idle;
    formatControl <= {mode, ps, 8'h00};
    txWord <= s[15:0];
    if (!idle) expTaken++;
    if (full) expRx.push_back(s[31:16]);
    u_sppm_host.xfer(mode[1], mode[0], s[31:16], n, 4, r);
    expOut = idle ? 16'h0000 : (s[15:0] >> (16 - n));
    `CHK("deviceOutWord", expOut, r)
    repeat (3) @(posedge core_clk);
    `CHK("outEnIdle", 1'b0, linkOut.deviceOutEn)
    `CHK("bitCountIdle", 5'h00, bitCount)
    `CHK("txTakenCount", expTaken, nTaken)
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int m = 0; m < 4; m++) frame(m[1:0], {6'h00, seed[25:24]}, 16);
    frame(2'b00, 8'h00, 5);
    frame(2'b11, 8'h01, 16);
    @(posedge core_clk);
    globalControl <= 32'h1;
    frame(2'b01, 8'h00, 16);
    globalControl <= 32'h0;
    `CHK("clockTooFastIdle", 1'b0, clockTooFast)
    frame(2'b00, 8'hff, 3);
    `CHK("clockTooFastSet", 1'b1, clockTooFast)
    `CHK("queueDrained", 0, expRx.size())
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    summarize();
  end
endmodule
`default_nettype wire
